// ==== verilog/orvr_pkg.sv ====
`default_nettype none
package orvr_pkg;
	localparam logic [7:0] ORVR_OFF_ROUTING   = 8'h23;
	localparam logic [7:0] ORVR_OFF_VOL_HPL   = 8'h24;
	localparam logic [7:0] ORVR_OFF_VOL_HPR   = 8'h25;
	localparam logic [7:0] ORVR_OFF_VOL_SPK   = 8'h26;
	localparam logic [7:0] ORVR_OFF_FIXED     = 8'h27;
	localparam logic [7:0] ORVR_OFF_DRV_LEFT  = 8'h28;
	localparam logic [7:0] ORVR_OFF_DRV_RIGHT = 8'h29;
	localparam logic [7:0] ORVR_RST_ROUTING   = 8'h00;
	localparam logic [7:0] ORVR_RST_VOL       = 8'h7f;
	localparam logic [7:0] ORVR_FIXED_VALUE   = 8'h7f;
	localparam logic [6:0] ORVR_RST_DRV       = 7'h02;
	localparam logic [3:0] ORVR_GAIN_MAX      = 4'h9;
	localparam int         ORVR_RAMP_CYCLES   = 16;
	localparam logic [1:0] ORVR_DAC_OPEN      = 2'b00;
	localparam logic [1:0] ORVR_DAC_MIXER     = 2'b01;
	localparam logic [1:0] ORVR_DAC_DIRECT    = 2'b10;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} orvr_bus_req_t;

	typedef struct packed {
		logic       dac_left_to_mixer;
		logic       dac_left_to_headphone;
		logic       analog_input_one_to_left_mixer;
		logic       analog_input_two_to_left_mixer;
		logic       dac_right_to_mixer;
		logic       dac_right_to_headphone;
		logic       analog_input_two_to_right_mixer;
		logic       left_hp_to_right_hp;
		logic       left_vol_to_left_hp;
		logic [6:0] left_hp_atten;
		logic       right_vol_to_right_hp;
		logic [6:0] right_hp_atten;
		logic       left_vol_to_speaker;
		logic [6:0] speaker_atten;
		logic [3:0] left_hp_gain;
		logic       left_hp_unmuted;
		logic       left_hp_hiz_pd;
		logic [3:0] right_hp_gain;
		logic       right_hp_unmuted;
		logic       right_hp_hiz_pd;
	} orvr_ctl_t;
endpackage
`default_nettype wire

// ==== verilog/orvr_regs.sv ====
`default_nettype none
module orvr_regs #(
	parameter int RAMP_CYCLES = orvr_pkg::ORVR_RAMP_CYCLES
) (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst_b,
	input  wire logic                  clk_en,
	// Register port
	input  wire orvr_pkg::orvr_bus_req_t bus_req,
	output logic [7:0]                 rdata,
	// Control to the analog path
	output orvr_pkg::orvr_ctl_t        ctl,
	output logic                       left_hp_gain_applied,
	output logic                       right_hp_gain_applied
);
	import orvr_pkg::*;

	typedef struct packed {
		logic [7:0]  routing;
		logic [7:0]  vol_hpl;
		logic [7:0]  vol_hpr;
		logic [7:0]  vol_spk;
		logic [6:0]  drv_l;
		logic [6:0]  drv_r;
		logic [15:0] ramp_l;
		logic [15:0] ramp_r;
		logic        done_l;
		logic        done_r;
		logic [7:0]  rdata;
	} orvr_state_t;

	orvr_state_t st;
	orvr_state_t next_st;

	// Out-of-range gain codes are clamped so the driver never sees them
	function automatic logic [3:0] orvr_gain(input logic [3:0] code);
		orvr_gain = (code > ORVR_GAIN_MAX) ? ORVR_GAIN_MAX : code;
	endfunction

	always_comb begin
		next_st = st;
		// Ramps count down; flag sets when the count reaches zero
		if (st.ramp_l != 16'h0000) begin
			next_st.ramp_l = st.ramp_l - 16'h0001;
			if (st.ramp_l == 16'h0001) begin
				next_st.done_l = 1'b1;
			end
		end
		if (st.ramp_r != 16'h0000) begin
			next_st.ramp_r = st.ramp_r - 16'h0001;
			if (st.ramp_r == 16'h0001) begin
				next_st.done_r = 1'b1;
			end
		end
		next_st.rdata = 8'h00;
		if (bus_req.rd) begin
			case (bus_req.addr)
				ORVR_OFF_ROUTING:   next_st.rdata = st.routing;
				ORVR_OFF_VOL_HPL:   next_st.rdata = st.vol_hpl;
				ORVR_OFF_VOL_HPR:   next_st.rdata = st.vol_hpr;
				ORVR_OFF_VOL_SPK:   next_st.rdata = st.vol_spk;
				ORVR_OFF_FIXED:     next_st.rdata = ORVR_FIXED_VALUE;
				ORVR_OFF_DRV_LEFT:  next_st.rdata = {1'b0, st.drv_l[6:1], st.done_l};
				ORVR_OFF_DRV_RIGHT: next_st.rdata = {1'b0, st.drv_r[6:1], st.done_r};
				default:            next_st.rdata = 8'h00;
			endcase
		end
		if (bus_req.wr) begin
			case (bus_req.addr)
				ORVR_OFF_ROUTING: next_st.routing = bus_req.wdata;
				ORVR_OFF_VOL_HPL: next_st.vol_hpl = bus_req.wdata;
				ORVR_OFF_VOL_HPR: next_st.vol_hpr = bus_req.wdata;
				ORVR_OFF_VOL_SPK: next_st.vol_spk = bus_req.wdata;
				ORVR_OFF_DRV_LEFT: begin
					// Top bit ignored, status bit not writable
					next_st.drv_l  = {bus_req.wdata[6:1], 1'b0};
					next_st.ramp_l = 16'(RAMP_CYCLES);
					next_st.done_l = 1'b0;
				end
				ORVR_OFF_DRV_RIGHT: begin
					next_st.drv_r  = {bus_req.wdata[6:1], 1'b0};
					next_st.ramp_r = 16'(RAMP_CYCLES);
					next_st.done_r = 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st         <= '0;
			st.routing <= ORVR_RST_ROUTING;
			st.vol_hpl <= ORVR_RST_VOL;
			st.vol_hpr <= ORVR_RST_VOL;
			st.vol_spk <= ORVR_RST_VOL;
			st.drv_l   <= ORVR_RST_DRV;
			st.drv_r   <= ORVR_RST_DRV;
			st.done_l  <= 1'b1;
			st.done_r  <= 1'b1;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign rdata                 = st.rdata;
	assign left_hp_gain_applied  = st.done_l;
	assign right_hp_gain_applied = st.done_r;

	always_comb begin
		ctl.dac_left_to_mixer      = (st.routing[7:6] == ORVR_DAC_MIXER);
		ctl.dac_left_to_headphone  = (st.routing[7:6] == ORVR_DAC_DIRECT);
		ctl.analog_input_one_to_left_mixer     = st.routing[5];
		ctl.analog_input_two_to_left_mixer     = st.routing[4];
		ctl.dac_right_to_mixer     = (st.routing[3:2] == ORVR_DAC_MIXER);
		ctl.dac_right_to_headphone = (st.routing[3:2] == ORVR_DAC_DIRECT);
		ctl.analog_input_two_to_right_mixer    = st.routing[1];
		ctl.left_hp_to_right_hp    = st.routing[0];
		ctl.left_vol_to_left_hp    = st.vol_hpl[7];
		ctl.left_hp_atten          = st.vol_hpl[6:0];
		ctl.right_vol_to_right_hp  = st.vol_hpr[7];
		ctl.right_hp_atten         = st.vol_hpr[6:0];
		ctl.left_vol_to_speaker    = st.vol_spk[7];
		ctl.speaker_atten          = st.vol_spk[6:0];
		// Driver state holds bits 6..1 of the register at the same positions
		ctl.left_hp_gain           = orvr_gain(st.drv_l[6:3]);
		ctl.left_hp_unmuted        = st.drv_l[2];
		ctl.left_hp_hiz_pd         = st.drv_l[1];
		ctl.right_hp_gain          = orvr_gain(st.drv_r[6:3]);
		ctl.right_hp_unmuted       = st.drv_r[2];
		ctl.right_hp_hiz_pd        = st.drv_r[1];
	end

	// Assertions
	chk_fixed_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && bus_req.rd && bus_req.addr == ORVR_OFF_FIXED |=> rdata == 8'h7f)
		else $error("fixed slot read wrong");
	chk_left_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && bus_req.wr && bus_req.addr == ORVR_OFF_DRV_LEFT |=> !left_hp_gain_applied)
		else $error("left flag not cleared");
	chk_right_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && bus_req.wr && bus_req.addr == ORVR_OFF_DRV_RIGHT |=> !right_hp_gain_applied)
		else $error("right flag not cleared");
	chk_left_mix: assert property (@(posedge core_clk) disable iff (!rst_b)
		!(ctl.dac_left_to_mixer && ctl.dac_left_to_headphone))
		else $error("left dac routed twice");
	chk_right_mix: assert property (@(posedge core_clk) disable iff (!rst_b)
		!(ctl.dac_right_to_mixer && ctl.dac_right_to_headphone))
		else $error("right dac routed twice");
	chk_gain_left: assert property (@(posedge core_clk) disable iff (!rst_b)
		ctl.left_hp_gain <= 4'h9)
		else $error("left gain out of range");
	chk_gain_right: assert property (@(posedge core_clk) disable iff (!rst_b)
		ctl.right_hp_gain <= 4'h9)
		else $error("right gain out of range");
	chk_route_write: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && bus_req.wr && bus_req.addr == ORVR_OFF_ROUTING
		|=> ctl.analog_input_one_to_left_mixer == $past(bus_req.wdata[5]))
		else $error("routing write lost");
	chk_mute_write: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en && bus_req.wr && bus_req.addr == ORVR_OFF_DRV_LEFT
		|=> ctl.left_hp_unmuted == $past(bus_req.wdata[2]))
		else $error("mute write lost");
endmodule
`default_nettype wire

// ==== verification/orvr_regs_tb.sv ====
`default_nettype none
module orvr_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import orvr_pkg::*;
	localparam int RAMP = 4;
	localparam logic [15:0] CORNER [6] = '{16'h28ff, 16'h294c, 16'h2700, 16'h2a55, 16'h23c0, 16'h239b};
	logic          core_clk = 1'b0;
	logic          rst_b    = 1'b0;
	logic          clk_en   = 1'b1;
	orvr_bus_req_t bus_req  = '0;
	logic [7:0]    rdata;
	orvr_ctl_t     ctl;
	logic          left_ok;
	logic          right_ok;
	int            n_errors = 0;
	int            n_tests  = 0;
	logic [31:0]   seed     = 32'he6ce_84b1;
	logic [7:0]    m [35:41];

	orvr_regs #(.RAMP_CYCLES(RAMP)) dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .bus_req(bus_req),
		.rdata(rdata), .ctl(ctl), .left_hp_gain_applied(left_ok), .right_hp_gain_applied(right_ok));

	always #12.5 core_clk = ~core_clk;

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	function automatic logic [3:0] gain(logic [7:0] r);
		return (r[6:3] > ORVR_GAIN_MAX) ? ORVR_GAIN_MAX : r[6:3];
	endfunction

	function automatic orvr_ctl_t exp_ctl();
		return {m[35][7:6] == ORVR_DAC_MIXER, m[35][7:6] == ORVR_DAC_DIRECT, m[35][5:4],
			m[35][3:2] == ORVR_DAC_MIXER, m[35][3:2] == ORVR_DAC_DIRECT, m[35][1:0], m[36], m[37], m[38],
			gain(m[40]), m[40][2:1], gain(m[41]), m[41][2:1]};
	endfunction

	// Driver registers read back with the applied flag set once the ramp is over
	function automatic logic [7:0] exp_rd(logic [7:0] a);
		if (a < ORVR_OFF_ROUTING || a > ORVR_OFF_DRV_RIGHT) return 8'h00;
		return m[a] | {7'h00, a > ORVR_OFF_FIXED};
	endfunction

	task automatic chk(string name, logic [43:0] exp, logic [43:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(posedge core_clk);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk);
		bus_req <= '0;
		@(negedge core_clk);
		chk("rdata", exp, rdata);
	endtask

	task automatic step(logic [7:0] a, logic [7:0] d);
		@(posedge core_clk);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk);
		bus_req <= '0;
		if (a >= ORVR_OFF_ROUTING && a <= ORVR_OFF_DRV_RIGHT && a != ORVR_OFF_FIXED) begin
			m[a] = (a > ORVR_OFF_FIXED) ? {1'b0, d[6:1], 1'b0} : d;
		end
		@(negedge core_clk);
		chk("left flag", a != ORVR_OFF_DRV_LEFT, left_ok);
		chk("right flag", a != ORVR_OFF_DRV_RIGHT, right_ok);
		chk("ctl", exp_ctl(), ctl);
		repeat (RAMP + 1) @(posedge core_clk);
		rd(a, exp_rd(a));
	endtask

	task automatic init_model();
		foreach (m[i]) m[i] = ORVR_RST_VOL;
		m[35] = ORVR_RST_ROUTING;
		m[40] = {1'b0, ORVR_RST_DRV};
		m[41] = {1'b0, ORVR_RST_DRV};
	endtask

	// A write while the enable is low must leave every control unchanged
	task automatic frozen_write();
		@(posedge core_clk);
		clk_en  <= 1'b0;
		bus_req <= '{ORVR_OFF_ROUTING, 8'hff, 1'b1, 1'b0};
		@(posedge core_clk);
		bus_req <= '0;
		clk_en  <= 1'b1;
		@(negedge core_clk);
		chk("ctl frozen", exp_ctl(), ctl);
	endtask

	task automatic print_verdict();
		if (n_errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		init_model();
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int a = 34; a < 43; a++) rd(8'(a), exp_rd(8'(a)));
		chk("ctl", exp_ctl(), ctl);
		foreach (CORNER[i]) step(CORNER[i][15:8], CORNER[i][7:0]);
		frozen_write();
		repeat (60) step(8'h22 + rnd() % 8'h09, rnd());
		@(posedge core_clk);
		rst_b <= 1'b0;
		@(posedge core_clk);
		rst_b <= 1'b1;
		init_model();
		for (int a = 35; a < 42; a++) rd(8'(a), exp_rd(8'(a)));
		chk("ctl after reset", exp_ctl(), ctl);
		print_verdict();
	end

	// Whole run is about 640 cycles; cut a hang well beyond that
	initial begin
		#100us;
		n_errors++;
		print_verdict();
	end
endmodule
`default_nettype wire
